// file: rtl/utc_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - Messages are 70 bits; only type code 0110 in bits 1-4 is accepted.
// - Subtype bits 5-6: 01 date content, 10 leap content, others reserved.
// - Bits 7-35 give 29-bit 10 us count within hour of next pulse group.
// - Decoded time is applied at first pulse of next pulse group.
// - Subtype 1: hour of year bits 36-49, year bits 50-55, bit 56 ignored.
// - Bits 1-35 and check bits 57-70 are common; middle 21 bits per subtype.
// - Subtype 2: precise time bits 36-45 in 10 ns, leap seconds 46-54.
// - Leap-second offset is a signed 9-bit two's-complement value.
// - Change bits 55-56: 00 none, 01 plus one, 10 minus one, 11 other.
// - Leap change takes effect at 1 January or 1 July midnight.
// - Change 11: drop received UTC after the moment until a new message.
// - Time base counts 10 us ticks; messages carry the tick index, subtype 2 also a 10 ns precise time.
// - Second pulse comes from counting the 10 MHz clock, aligned by messages.
// - Propagation delay offset is set by software or calibrated against GPS.
// - One-time alignment of the second pulse to the GPS second pulse.
// - Rising edge of the second pulse marks the UTC second.
// - Second pulse stays low until UTC is received or GPS sync is done.
module utc_decoder #(
  parameter logic [13:0] CRC_POLY = 14'h0001
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        bit_valid_i,
  input  wire logic        bit_data_i,
  input  wire logic        msg_start_i,
  input  wire logic        group_start_i,
  input  wire logic        gps_pps_i,
  output logic             pps_o,
  output logic             irq_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  import utc_pkg::*;

  localparam logic [6:0]  SUB_LAST = 7'(CYC_PER_TICK - 1);
  localparam logic [23:0] SEC_LAST = 24'(CLK_HZ - 1);
  localparam logic [28:0] HOUR_LAST = 29'(TICKS_PER_HOUR - 1);
  localparam logic [9:0]  PPS_LAST = 10'(PPS_HIGH_CYC - 1);

  function automatic logic [13:0] crc_step(input logic [13:0] c, input logic b);
    logic fb;
    fb = b ^ c[13];
    crc_step = {c[12:0], 1'b0} ^ (fb ? CRC_POLY : 14'h0000);
  endfunction : crc_step

  function automatic logic [23:0] sec_phase(input logic [28:0] t, input logic [9:0] p);
    int tick;
    int frac;
    tick = int'(t) % TICKS_PER_SEC;
    frac = int'(p) / PRECISE_PER_CYC;
    if (frac > CYC_PER_TICK - 1)
      frac = CYC_PER_TICK - 1;
    sec_phase = 24'(tick * CYC_PER_TICK + frac);
  endfunction : sec_phase

  // Receiver group
  utc_rx_e                rx_state, next_rx_state;
  logic [MSG_BITS-1:0]    sh, next_sh;
  logic [6:0]             bit_cnt, next_bit_cnt;
  logic [CRC_BITS-1:0]    crc, next_crc;
  logic                   ev_ok, ev_crc, apply;
  logic [MSG_BITS-1:0]    full;

  always_comb begin
    next_rx_state = rx_state;
    next_sh       = sh;
    next_bit_cnt  = bit_cnt;
    next_crc      = crc;
    ev_ok         = 1'b0;
    ev_crc        = 1'b0;
    apply         = 1'b0;
    full          = {sh[MSG_BITS-2:0], bit_data_i};
    case (rx_state)
      UTC_RX_IDLE, UTC_RX_BITS: begin
        if (bit_valid_i && (msg_start_i || rx_state == UTC_RX_BITS)) begin
          next_sh       = full;
          next_rx_state = UTC_RX_BITS;
          if (msg_start_i) begin
            next_bit_cnt = 7'h01;
            next_crc     = crc_step(14'h0000, bit_data_i);
          end else begin
            next_bit_cnt = 7'(bit_cnt + 7'h01);
            if (bit_cnt < 7'(CRC_COVER))
              next_crc = crc_step(crc, bit_data_i);
          end
          if (!msg_start_i && bit_cnt == 7'(MSG_BITS - 1)) begin
            next_rx_state = UTC_RX_IDLE;
            if (full[F_TYPE_LSB +: 4] == TYPE_UTC) begin
              if (crc == full[F_CRC_LSB +: CRC_BITS]) begin
                ev_ok         = 1'b1;
                next_rx_state = UTC_RX_ARMED;
              end else begin
                ev_crc = 1'b1;
              end
            end
          end
        end
      end
      UTC_RX_ARMED: begin
        if (group_start_i) begin
          apply         = 1'b1;
          next_rx_state = UTC_RX_IDLE;
        end
      end
      default: next_rx_state = UTC_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= UTC_RX_IDLE;
      sh       <= '0;
      bit_cnt  <= 7'h00;
      crc      <= 14'h0000;
    end else begin
      rx_state <= next_rx_state;
      sh       <= next_sh;
      bit_cnt  <= next_bit_cnt;
      crc      <= next_crc;
    end
  end

  // Timing and register group
  logic [6:0]          sub_cyc, next_sub_cyc;
  logic [23:0]         cyc_in_sec, next_cyc_in_sec;
  logic [28:0]         time_ticks, next_time_ticks;
  logic [13:0]         hour_of_year, next_hour_of_year;
  logic [5:0]          year, next_year;
  logic [9:0]          precise, next_precise;
  logic signed [8:0]   leap_sec, next_leap_sec;
  utc_chg_e            leap_chg, next_leap_chg;
  logic                date_valid, next_date_valid;
  logic                utc_valid, next_utc_valid;
  logic                utc_hold, next_utc_hold;
  logic                pps_en, next_pps_en;
  logic [9:0]          pps_cnt, next_pps_cnt;
  logic                next_pps;
  logic [23:0]         delay, next_delay;
  logic [23:0]         cal_meas, next_cal_meas;
  logic                cal_arm, next_cal_arm;
  logic                sync_arm, next_sync_arm;
  logic                sync_done, next_sync_done;
  logic                auto_cal, next_auto_cal;
  logic                gps_q;
  logic [IRQ_BITS-1:0] stat, next_stat, mask, next_mask, ev;
  logic [31:0]         next_dat, rd_data, wmask;
  logic                next_ack, wr, moment, gps_edge, pps_hit;
  logic [13:0]         next_hour;

  always_comb begin
    next_sub_cyc      = (sub_cyc == SUB_LAST) ? 7'h00 : 7'(sub_cyc + 7'h01);
    next_cyc_in_sec   = (cyc_in_sec == SEC_LAST) ? 24'h000000 : 24'(cyc_in_sec + 24'h000001);
    next_time_ticks   = time_ticks;
    next_hour_of_year = hour_of_year;
    next_year         = year;
    next_precise      = precise;
    next_leap_sec     = leap_sec;
    next_leap_chg     = leap_chg;
    next_date_valid   = date_valid;
    next_utc_valid    = utc_valid;
    next_utc_hold     = utc_hold;
    next_pps_en       = pps_en;
    next_delay        = delay;
    next_cal_meas     = cal_meas;
    next_cal_arm      = cal_arm;
    next_sync_arm     = sync_arm;
    next_sync_done    = sync_done;
    next_auto_cal     = auto_cal;
    next_mask         = mask;
    moment            = 1'b0;
    next_hour         = 14'(hour_of_year + 14'h0001);
    gps_edge          = gps_pps_i & ~gps_q;
    ev                = '0;
    ev[IRQ_MSG_OK]    = ev_ok;
    ev[IRQ_CRC_ERR]   = ev_crc;
    // Tick counter within the hour
    if (sub_cyc == SUB_LAST) begin
      if (time_ticks == HOUR_LAST) begin
        next_time_ticks = 29'h00000000;
        if (date_valid) begin
          if (next_hour == (year[1:0] == 2'b00 ? HOURS_LEAP_YEAR : HOURS_YEAR)) begin
            next_hour = 14'h0000;
            next_year = 6'(year + 6'h01);
            moment    = 1'b1;
          end else if (next_hour == (year[1:0] == 2'b00 ? JUL_HOUR_LEAP : JUL_HOUR)) begin
            moment = 1'b1;
          end
          next_hour_of_year = next_hour;
        end
      end else begin
        next_time_ticks = 29'(time_ticks + 29'h00000001);
      end
    end
    if (moment) begin
      case (leap_chg)
        UTC_CHG_PLUS:  next_leap_sec = 9'(leap_sec + 9'sh001);
        UTC_CHG_MINUS: next_leap_sec = 9'(leap_sec - 9'sh001);
        UTC_CHG_OTHER: begin
          next_utc_valid = 1'b0;
          next_utc_hold  = 1'b1;
        end
        default: next_leap_sec = leap_sec;
      endcase
      next_leap_chg = UTC_CHG_NONE;
      ev[IRQ_LEAP]  = 1'b1;
    end
    // Load decoded time at the first pulse of the next group
    if (apply) begin
      next_time_ticks = sh[F_TIME_LSB +: 29];
      next_sub_cyc    = 7'h00;
      next_cyc_in_sec = sec_phase(sh[F_TIME_LSB +: 29],
                                  sh[F_SUB_LSB +: 2] == SUB_LEAP ? sh[F_PREC_LSB +: 10] : 10'h000);
      next_utc_valid  = 1'b1;
      next_utc_hold   = 1'b0;
      next_pps_en     = 1'b1;
      case (sh[F_SUB_LSB +: 2])
        SUB_DATE: begin
          next_hour_of_year = sh[F_HOUR_LSB +: 14];
          next_year         = sh[F_YEAR_LSB +: 6];
          next_date_valid   = 1'b1;
        end
        SUB_LEAP: begin
          next_precise  = sh[F_PREC_LSB +: 10];
          next_leap_sec = $signed(sh[F_LEAP_LSB +: 9]);
          next_leap_chg = utc_chg_e'(sh[F_CHG_LSB +: 2]);
        end
        default: next_precise = precise;
      endcase
    end
    // GPS calibration and one-time alignment
    if (gps_edge && cal_arm) begin
      next_cal_meas = cyc_in_sec;
      next_cal_arm  = 1'b0;
      ev[IRQ_CAL]   = 1'b1;
      if (auto_cal)
        next_delay = cyc_in_sec;
    end
    if (gps_edge && sync_arm) begin
      next_cyc_in_sec = 24'h000000;
      next_sub_cyc    = 7'h00;
      next_delay      = 24'h000001;
      next_sync_arm   = 1'b0;
      next_sync_done  = 1'b1;
      next_pps_en     = 1'b1;
    end
    // Second pulse with delay offset, rising edge on the second
    pps_hit      = pps_en && cyc_in_sec == delay;
    next_pps     = pps_o;
    next_pps_cnt = pps_cnt;
    if (pps_hit) begin
      next_pps     = 1'b1;
      next_pps_cnt = 10'h000;
      ev[IRQ_PPS]  = 1'b1;
    end else if (pps_o) begin
      next_pps_cnt = 10'(pps_cnt + 10'h001);
      if (pps_cnt == PPS_LAST)
        next_pps = 1'b0;
    end
    // Bus slave
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr       = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    case (wb_adr_i)
      REG_CTRL:     rd_data = 32'(auto_cal);
      REG_STATUS:   rd_data = {26'h0000000, sync_done, date_valid, utc_hold,
                               pps_en, utc_valid, rx_state == UTC_RX_ARMED};
      REG_IRQ_STAT: rd_data = 32'(stat);
      REG_IRQ_MASK: rd_data = 32'(mask);
      REG_DELAY:    rd_data = 32'(delay);
      REG_TIME:     rd_data = 32'(time_ticks);
      REG_DATE:     rd_data = (32'(year) << DATE_YEAR_LSB) | 32'(hour_of_year);
      REG_LEAP:     rd_data = (32'(leap_chg) << LEAP_CHG_LSB)
                              | (32'(unsigned'(leap_sec)) << LEAP_SEC_LSB) | 32'(precise);
      REG_CAL:      rd_data = 32'(cal_meas);
      default:      rd_data = 32'h00000000;
    endcase
    next_dat  = next_ack ? rd_data : 32'h00000000;
    next_stat = stat;
    if (wr) begin
      case (wb_adr_i)
        REG_CTRL: begin
          if (wb_sel_i[0]) begin
            next_auto_cal = wb_dat_i[CTRL_AUTO_CAL];
            if (wb_dat_i[CTRL_CAL_REQ])
              next_cal_arm = 1'b1;
            if (wb_dat_i[CTRL_GPS_SYNC] && !sync_done)
              next_sync_arm = 1'b1;
          end
        end
        REG_IRQ_STAT: if (wb_sel_i[0]) next_stat = stat & ~wb_dat_i[IRQ_BITS-1:0];
        REG_IRQ_MASK: if (wb_sel_i[0]) next_mask = wb_dat_i[IRQ_BITS-1:0];
        REG_DELAY:    next_delay = ((delay & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]));
        default:      next_mask = mask;
      endcase
    end
    next_stat = next_stat | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_cyc      <= 7'h00;
      cyc_in_sec   <= 24'h000000;
      time_ticks   <= 29'h00000000;
      hour_of_year <= 14'h0000;
      year         <= 6'h00;
      precise      <= 10'h000;
      leap_sec     <= 9'sh000;
      leap_chg     <= UTC_CHG_NONE;
      date_valid   <= 1'b0;
      utc_valid    <= 1'b0;
      utc_hold     <= 1'b0;
      pps_en       <= 1'b0;
      pps_cnt      <= 10'h000;
      pps_o        <= 1'b0;
      delay        <= RST_DELAY;
      cal_meas     <= 24'h000000;
      cal_arm      <= 1'b0;
      sync_arm     <= 1'b0;
      sync_done    <= 1'b0;
      auto_cal     <= 1'b0;
      gps_q        <= 1'b0;
      stat         <= '0;
      mask         <= RST_MASK;
      irq_o        <= 1'b0;
      wb_dat_o     <= 32'h00000000;
      wb_ack_o     <= 1'b0;
    end else begin
      sub_cyc      <= next_sub_cyc;
      cyc_in_sec   <= next_cyc_in_sec;
      time_ticks   <= next_time_ticks;
      hour_of_year <= next_hour_of_year;
      year         <= next_year;
      precise      <= next_precise;
      leap_sec     <= next_leap_sec;
      leap_chg     <= next_leap_chg;
      date_valid   <= next_date_valid;
      utc_valid    <= next_utc_valid;
      utc_hold     <= next_utc_hold;
      pps_en       <= next_pps_en;
      pps_cnt      <= next_pps_cnt;
      pps_o        <= next_pps;
      delay        <= next_delay;
      cal_meas     <= next_cal_meas;
      cal_arm      <= next_cal_arm;
      sync_arm     <= next_sync_arm;
      sync_done    <= next_sync_done;
      auto_cal     <= next_auto_cal;
      gps_q        <= gps_pps_i;
      stat         <= next_stat;
      mask         <= next_mask;
      irq_o        <= |(next_stat & next_mask);
      wb_dat_o     <= next_dat;
      wb_ack_o     <= next_ack;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  msg_type_a: assert property (apply |-> sh[F_TYPE_LSB +: 4] == TYPE_UTC)
    else $error("applied message has wrong type");
  msg_check_a: assert property (ev_ok |-> crc == full[F_CRC_LSB +: CRC_BITS]
    ##1 stat[IRQ_MSG_OK] && rx_state == UTC_RX_ARMED) else $error("accepted message not armed");
  time_load_a: assert property (apply |=> time_ticks == $past(sh[F_TIME_LSB +: 29]))
    else $error("time not loaded at group start");
  date_load_a: assert property (apply && sh[F_SUB_LSB +: 2] == SUB_DATE
    |=> hour_of_year == $past(sh[F_HOUR_LSB +: 14]) && year == $past(sh[F_YEAR_LSB +: 6]))
    else $error("date fields not loaded");
  leap_load_a: assert property (apply && sh[F_SUB_LSB +: 2] == SUB_LEAP
    |=> leap_sec == $signed($past(sh[F_LEAP_LSB +: 9])) && precise == $past(sh[F_PREC_LSB +: 10]))
    else $error("leap fields not loaded");
  tick_range_a: assert property (sub_cyc <= SUB_LAST)
    else $error("tick divider out of range");
  sec_count_a: assert property (!apply && !(gps_edge && sync_arm) && cyc_in_sec != SEC_LAST
    |=> cyc_in_sec == $past(cyc_in_sec) + 24'h000001)
    else $error("second counter skipped");
  pps_mark_a: assert property ($rose(pps_o) |-> $past(cyc_in_sec) == $past(delay))
    else $error("pulse rose off the delayed second");
  pps_gate_a: assert property (!pps_en |=> !$rose(pps_o))
    else $error("pulse before time was known");
  hold_set_a: assert property (moment && leap_chg == UTC_CHG_OTHER && !apply
    |=> !utc_valid && utc_hold)
    else $error("received time kept after unknown change");
  irq_level_a: assert property (irq_o == |(stat & mask))
    else $error("interrupt does not follow masked status");

  apply_c: cover property (apply);
  pps_c: cover property ($rose(pps_o));
  crc_err_c: cover property (ev_crc);
  cal_c: cover property (gps_edge && cal_arm);
endmodule : utc_decoder

// file: rtl/utc_pkg.sv
package utc_pkg;
  // Clock and time base
  localparam longint CLK_HZ          = 10_000_000;
  localparam longint TICK_NS         = 10_000;
  localparam longint PPS_HIGH_NS     = 100_000;
  localparam int     CYC_PER_TICK    = int'(TICK_NS * CLK_HZ / 1_000_000_000);
  localparam int     TICKS_PER_SEC   = int'(CLK_HZ / CYC_PER_TICK);
  localparam int     SEC_PER_HOUR    = 3600;
  localparam int     TICKS_PER_HOUR  = TICKS_PER_SEC * SEC_PER_HOUR;
  localparam int     PPS_HIGH_CYC    = int'(PPS_HIGH_NS * CLK_HZ / 1_000_000_000);
  localparam int     PRECISE_PER_CYC = 10;

  // Calendar
  localparam logic [13:0] HOURS_YEAR      = 14'h2238;
  localparam logic [13:0] HOURS_LEAP_YEAR = 14'h2250;
  localparam logic [13:0] JUL_HOUR        = 14'h10F8;
  localparam logic [13:0] JUL_HOUR_LEAP   = 14'h1110;

  // Message layout, first received bit lands in bit MSG_BITS-1
  localparam int          MSG_BITS   = 70;
  localparam int          CRC_BITS   = 14;
  localparam int          CRC_COVER  = 56;
  localparam logic [3:0]  TYPE_UTC   = 4'h6;
  localparam logic [1:0]  SUB_DATE   = 2'h1;
  localparam logic [1:0]  SUB_LEAP   = 2'h2;
  localparam int          F_TYPE_LSB = 66;
  localparam int          F_SUB_LSB  = 64;
  localparam int          F_TIME_LSB = 35;
  localparam int          F_HOUR_LSB = 21;
  localparam int          F_YEAR_LSB = 15;
  localparam int          F_PREC_LSB = 25;
  localparam int          F_LEAP_LSB = 16;
  localparam int          F_CHG_LSB  = 14;
  localparam int          F_CRC_LSB  = 0;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_DELAY    = 8'h10;
  localparam logic [7:0] REG_TIME     = 8'h14;
  localparam logic [7:0] REG_DATE     = 8'h18;
  localparam logic [7:0] REG_LEAP     = 8'h1C;
  localparam logic [7:0] REG_CAL      = 8'h20;

  // Field positions
  localparam int CTRL_AUTO_CAL = 0;
  localparam int CTRL_CAL_REQ  = 1;
  localparam int CTRL_GPS_SYNC = 2;
  localparam int DATE_YEAR_LSB = 16;
  localparam int LEAP_SEC_LSB  = 16;
  localparam int LEAP_CHG_LSB  = 28;
  localparam int IRQ_BITS      = 5;
  localparam int IRQ_MSG_OK    = 0;
  localparam int IRQ_CRC_ERR   = 1;
  localparam int IRQ_PPS       = 2;
  localparam int IRQ_LEAP      = 3;
  localparam int IRQ_CAL       = 4;

  // Reset values
  localparam logic [23:0]         RST_DELAY = 24'h000000;
  localparam logic [IRQ_BITS-1:0] RST_MASK  = 5'h00;

  typedef enum logic [1:0] {
    UTC_CHG_NONE  = 2'b00,
    UTC_CHG_PLUS  = 2'b01,
    UTC_CHG_MINUS = 2'b10,
    UTC_CHG_OTHER = 2'b11
  } utc_chg_e;

  typedef enum logic [1:0] {
    UTC_RX_IDLE  = 2'b00,
    UTC_RX_BITS  = 2'b01,
    UTC_RX_ARMED = 2'b10
  } utc_rx_e;
endpackage : utc_pkg

// file: verification/utc_link_model.sv
`timescale 1ns/1ps
module utc_link_model (
  input  wire logic clk_i,
  output logic      bit_valid_o,
  output logic      bit_data_o,
  output logic      msg_start_o,
  output logic      group_start_o,
  output logic      gps_pps_o
);
  initial begin
    bit_valid_o   = 1'b0;
    bit_data_o    = 1'b0;
    msg_start_o   = 1'b0;
    group_start_o = 1'b0;
    gps_pps_o     = 1'b0;
  end

  // First bit first; gap idle cycles after each bit, data line toggles while idle
  task automatic send_msg(input logic [69:0] msg, input int gap);
    for (int i = 69; i >= 0; i--) begin
      @(posedge clk_i);
      bit_valid_o <= 1'b1;
      bit_data_o  <= msg[i];
      msg_start_o <= (i == 69);
      repeat (gap) begin
        @(posedge clk_i);
        bit_valid_o <= 1'b0;
        msg_start_o <= 1'b0;
        bit_data_o  <= ~bit_data_o;
      end
    end
    @(posedge clk_i);
    bit_valid_o <= 1'b0;
    msg_start_o <= 1'b0;
    bit_data_o  <= ~msg[0];
  endtask : send_msg

  // Pulse groups start on the next clock edge, one strobe per group
  task automatic pulse_group;
    @(posedge clk_i);
    group_start_o <= 1'b1;
    @(posedge clk_i);
    group_start_o <= 1'b0;
  endtask : pulse_group

  task automatic gps_edge;
    @(posedge clk_i);
    gps_pps_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    gps_pps_o <= 1'b0;
  endtask : gps_edge
endmodule : utc_link_model

// file: verification/utc_message_decoder_pps_test.sv
`timescale 1ns/1ps
module utc_message_decoder_pps_test;
  import utc_pkg::*;
  localparam logic [13:0] POLY = 14'h0001;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we  = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic        bit_valid, bit_data, msg_start, group_start, gps_pps;
  logic        pps_o, irq_o, wb_ack_o;
  logic [31:0] wb_dat_o;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;
  logic [28:0] tim;
  logic [13:0] hour;
  logic [5:0]  year;
  logic [9:0]  prec;
  logic [8:0]  leap;
  logic        seen;

  always #50 clk_i = ~clk_i;

  utc_link_model i_link (.clk_i(clk_i), .bit_valid_o(bit_valid), .bit_data_o(bit_data),
    .msg_start_o(msg_start), .group_start_o(group_start), .gps_pps_o(gps_pps));

  utc_decoder #(.CRC_POLY(POLY)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .bit_valid_i(bit_valid), .bit_data_i(bit_data), .msg_start_i(msg_start),
    .group_start_i(group_start), .gps_pps_i(gps_pps), .pps_o(pps_o), .irq_o(irq_o),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks++;
    if (seen_v !== exp_v) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    wb_sel <= sel;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp_v, input logic [31:0] msk);
    exp_q.push_back(exp_v);
    msk_q.push_back(msk);
    wb_xfer(1'b0, adr, 32'h0, 4'hF);
  endtask : rd

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hF);
  endtask : wr

  function automatic logic [69:0] mk_msg(input logic [3:0] typ, input logic [1:0] sub,
                                         input logic [28:0] t, input logic [20:0] mid);
    logic [55:0] body;
    logic [13:0] crc;
    body = {typ, sub, t, mid};
    crc  = 14'h0000;
    for (int i = 55; i >= 0; i--) begin
      crc = {crc[12:0], 1'b0} ^ ((crc[13] ^ body[i]) ? POLY : 14'h0000);
    end
    return {body, crc};
  endfunction : mk_msg

  // Read results are compared against the oldest note; also cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      tally_and_finish();
    end
    if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
      end else begin
        check(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  initial begin
    void'($urandom(32'h9713C4EE));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REG_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
    rd(REG_DELAY, 32'h0, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    seen = 1'b0;
    repeat (200) begin
      @(posedge clk_i);
      if (pps_o !== 1'b0) seen = 1'b1;
    end
    check(32'(seen), 32'h0);
    // Date message on a whole second, spare bit set, then second pulse
    tim  = 29'(($urandom % 3600) * 100000);
    hour = 14'($urandom % 8784);
    year = 6'($urandom);
    wr(REG_IRQ_MASK, 32'h1);
    wr(REG_DELAY, 32'h5);
    i_link.send_msg(mk_msg(TYPE_UTC, SUB_DATE, tim, {hour, year, 1'b1}), 0);
    repeat (2) @(posedge clk_i);
    check(32'(irq_o), 32'h1);
    rd(REG_STATUS, 32'h1, 32'h5);
    i_link.pulse_group();
    rd(REG_TIME, 32'(tim), 32'h1FFFFFFF);
    n = 0;
    while (pps_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n < 100), 32'h1);
    n = 0;
    while (pps_o === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    check(n, PPS_HIGH_CYC);
    rd(REG_DATE, {10'h0, year, 2'h0, hour}, 32'h003F3FFF);
    rd(REG_STATUS, 32'h4, 32'h5);
    wr(REG_IRQ_STAT, 32'h1F);
    @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    // Corrupted check field, then a foreign message type
    i_link.send_msg(mk_msg(TYPE_UTC, SUB_DATE, tim + 29'd7, 21'h0) ^ 70'h1, 1);
    repeat (2) @(posedge clk_i);
    rd(REG_IRQ_STAT, 32'h2, 32'h3);
    i_link.send_msg(mk_msg(4'h5, SUB_DATE, tim + 29'd9, 21'h0), 0);
    repeat (2) @(posedge clk_i);
    rd(REG_STATUS, 32'h0, 32'h1);
    i_link.pulse_group();
    rd(REG_DATE, {10'h0, year, 2'h0, hour}, 32'h003F3FFF);
    // Every change code, one negative offset
    for (int c = 0; c < 4; c++) begin
      tim  = 29'($urandom % TICKS_PER_HOUR);
      prec = 10'($urandom % 1000);
      leap = (c == 2) ? 9'h1F0 : 9'($urandom);
      i_link.send_msg(mk_msg(TYPE_UTC, SUB_LEAP, tim, {prec, leap, 2'(c)}), c);
      i_link.pulse_group();
      rd(REG_TIME, 32'(tim), 32'h1FFFFFFF);
      rd(REG_LEAP, {2'h0, 2'(c), 3'h0, leap, 6'h0, prec}, 32'h31FF03FF);
    end
    // Last tick of a common year while change 11 is pending
    tim  = 29'(TICKS_PER_HOUR - 1);
    hour = 14'(HOURS_YEAR - 14'h0001);
    i_link.send_msg(mk_msg(TYPE_UTC, SUB_DATE, tim, {hour, 6'h01, 1'b0}), 0);
    i_link.pulse_group();
    repeat (120) @(posedge clk_i);
    rd(REG_STATUS, 32'h8, 32'hA);
    rd(REG_DATE, 32'h00020000, 32'h003F3FFF);
    rd(REG_IRQ_STAT, 32'h8, 32'h8);
    wr(REG_CTRL, 32'h4);
    i_link.gps_edge();
    repeat (2) @(posedge clk_i);
    rd(REG_DELAY, 32'h1, 32'hFFFFFF);
    rd(REG_STATUS, 32'h24, 32'h24);
    wb_xfer(1'b1, REG_DELAY, 32'hAABBCC, 4'h2);
    rd(REG_DELAY, 32'h00BB01, 32'hFFFFFF);
    // Calibration edge lands 26 cycles after the sync edge: counter reads 25
    wr(REG_CTRL, 32'h3);
    i_link.gps_edge();
    rd(REG_CAL, 32'h19, 32'hFFFFFF);
    rd(REG_DELAY, 32'h19, 32'hFFFFFF);
    tally_and_finish();
  end
endmodule : utc_message_decoder_pps_test
